// *** hdl/dual_compute_register_file.sv ***
//----------------------------------------------------------------------
// Purpose: Data register files, load alignment and special registers of
//          two compute blocks, with operand interlocking.
// Assumes: Compute units and buses run on mclk; single register port.
// Notes:   Data and special contents are not reset, except the status, which reset clears.
//----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module dual_compute_register_file
	import dcrf_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Register port
	input  wire logic [BUS_AW-1:0] bus_addr,
	input  wire logic [DW-1:0]     bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic [DW-1:0]          bus_rdata_r,
	output logic                   ext_bus_busy_r,
	// Instruction issue and operands
	input  wire instr_s            instr,
	output logic                   issue_ok_r,
	output logic                   issue_stall_r,
	output logic                   issue_err_r,
	output logic [1:0][QW-1:0]     opnd_m_r,
	output logic [1:0][QW-1:0]     opnd_n_r,
	// Results, loads and unit events
	input  wire wb_s               wb,
	input  wire ld_s               ld,
	input  wire flag_s             unit_flags,
	input  wire par_s              par,
	input  wire logic              bfo_wr,
	input  wire blk_sel_e          bfo_blk,
	input  wire logic [DW-1:0]     bfo_wdata,
	// Special register access
	input  wire spec_req_s         spec,
	output logic [DW-1:0]          spec_rdata_r,
	output logic [1:0][DW-1:0]     bfo_q_r,
	output logic [1:0]             exc_r
);

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	function automatic logic [1:0] blk_mask(input blk_sel_e sel);
		blk_mask = {sel != SEL_X, sel != SEL_Y};
	endfunction : blk_mask

	function automatic logic [2:0] wcount(input width_e w);
		case (w)
			W_DOUBLE: wcount = 3'd2;
			W_QUAD:   wcount = 3'd4;
			default:  wcount = 3'd1;
		endcase
	endfunction : wcount

	function automatic logic aligned(input logic [4:0] r, input width_e w);
		case (w)
			W_DOUBLE: aligned = (r[0] == 1'b0);
			W_QUAD:   aligned = (r[1:0] == 2'b00);
			W_SINGLE: aligned = 1'b1;
			default:  aligned = 1'b0;
		endcase
	endfunction : aligned

	function automatic logic [31:0] span(input logic [4:0] r,
		input width_e w);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (3'(i) < wcount(w))
				m[5'(r + 5'(i))] = 1'b1;
		end
		span = m;
	endfunction : span

	function automatic logic [127:0] rdq(input logic [31:0][31:0] rf,
		input logic [4:0] r, input width_e w);
		logic [127:0] q;
		q = '0;
		for (int i = 0; i < 4; i++)
		begin
			if (3'(i) < wcount(w))
				q[i*32 +: 32] = rf[5'(r + 5'(i))];
		end
		rdq = q;
	endfunction : rdq

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	state_s st_r;
	state_s st_nxt;

	logic [1:0]   sel_i;
	logic [1:0]   sel_wb;
	logic [1:0]   sel_ld;
	logic [1:0]   sel_fl;
	logic [1:0]   sel_pr;
	logic [1:0]   sel_bf;
	logic [1:0]   sel_sp;
	logic [31:0]  need;
	logic         conflict;
	logic         bad;
	logic [255:0] cat;
	logic [127:0] ld_q;
	logic [31:0]  pend_eff;
	logic         sb;
	logic [3:0]   grp_m;
	logic [3:0]   grp_a;

	always_comb
	begin
		st_nxt   = st_r;
		cat      = '0;
		ld_q     = '0;
		pend_eff = '0;
		grp_m    = '0;
		grp_a    = '0;
		sel_i    = blk_mask(instr.blk);
		sel_wb   = wb.valid ? blk_mask(wb.blk) : 2'b00;
		sel_ld   = ld.valid ? blk_mask(ld.blk) : 2'b00;
		sel_fl   = unit_flags.valid ? blk_mask(unit_flags.blk) : 2'b00;
		sel_pr   = par.valid ? blk_mask(par.blk) : 2'b00;
		sel_bf   = bfo_wr ? blk_mask(bfo_blk) : 2'b00;
		sel_sp   = (spec.blk == SEL_Y) ? 2'b10 : 2'b01;
		need     = span(instr.srcm, instr.width)
		         | span(instr.srcn, instr.width);
		if (instr.has_dst)
			need = need | span(instr.dst, instr.width);
		// A slot whose two sources name one register, or that is misaligned, is refused.
		bad = (instr.srcm == instr.srcn)
		    || !aligned(instr.srcm, instr.width)
		    || !aligned(instr.srcn, instr.width)
		    || (instr.has_dst && !aligned(instr.dst, instr.width));
		conflict = 1'b0;

		// Same-cycle results release their registers first; returns to
		// the multiplier registers too, else their target stalls forever.
		for (int b = 0; b < 2; b++)
		begin
			pend_eff = st_r.b[b].pend;
			if (sel_wb[b])
				pend_eff = pend_eff & ~span(wb.dst, wb.width);
			st_nxt.b[b].pend = pend_eff;
			if (sel_i[b] && ((need & pend_eff) != '0))
				conflict = 1'b1;
		end

		st_nxt.iss_ok    = instr.valid && !bad && !conflict;
		st_nxt.iss_stall = instr.valid && !bad && conflict;
		st_nxt.iss_err   = instr.valid && bad;

		for (int b = 0; b < 2; b++)
		begin
			// Operands always come from the block's own file.
			if (st_nxt.iss_ok && sel_i[b])
			begin
				st_nxt.opm[b] = rdq(st_r.b[b].regs, instr.srcm,
					instr.width);
				st_nxt.opn[b] = rdq(st_r.b[b].regs, instr.srcn,
					instr.width);
				if (instr.has_dst)
					st_nxt.b[b].pend = st_nxt.b[b].pend
						| span(instr.dst, instr.width);
			end

			// Register port writes land first; loads and results win.
			if (bus_wr && (bus_addr[7:5] == 3'(b)))
				st_nxt.b[b].regs[bus_addr[4:0]] = bus_wdata;

			if (sel_ld[b])
			begin
				ld_q = ld.data;
				if (ld.dab)
				begin
					// Quad entries shift through two stages; the
					// aligned view spans the newest and previous one.
					cat = {ld.data, st_r.b[b].dab[0]} >> {ld.offs, 5'd0};
					ld_q = cat[127:0];
					st_nxt.b[b].dab[1] = st_r.b[b].dab[0];
					st_nxt.b[b].dab[0] = ld.data;
				end
				for (int i = 0; i < 4; i++)
				begin
					if (3'(i) < wcount(ld.width))
						st_nxt.b[b].regs[5'(ld.dst + 5'(i))] =
							ld_q[i*32 +: 32];
				end
			end

			if (sel_wb[b])
			begin
				if (wb.to_mr)
				begin
					for (int i = 0; i < 4; i++)
						st_nxt.b[b].mr[i] = wb.data[i*32 +: 32];
					st_nxt.b[b].mr4 = wb.ovf;
				end
				else
				begin
					for (int i = 0; i < 4; i++)
					begin
						if (3'(i) < wcount(wb.width))
							st_nxt.b[b].regs[5'(wb.dst + 5'(i))] =
								wb.data[i*32 +: 32];
					end
				end
			end

			if (sel_pr[b])
			begin
				st_nxt.b[b].pr[0] = par.data[31:0];
				st_nxt.b[b].pr[1] = par.data[63:32];
			end

			if (sel_bf[b])
				st_nxt.b[b].bfo = bfo_wdata;

			// Software writes the status; new unit flags still set.
			sb = spec.wr && sel_sp[b] && (spec.sel == SP_STAT);
			if (sb)
				st_nxt.b[b].stat = spec.wdata & STAT_WMASK;
			if (spec.wr && sel_sp[b])
			begin
				case (spec.sel)
					SP_PR0:  st_nxt.b[b].pr[0] = spec.wdata;
					SP_PR1:  st_nxt.b[b].pr[1] = spec.wdata;
					SP_MR0:  st_nxt.b[b].mr[0] = spec.wdata;
					SP_MR1:  st_nxt.b[b].mr[1] = spec.wdata;
					SP_MR2:  st_nxt.b[b].mr[2] = spec.wdata;
					SP_MR3:  st_nxt.b[b].mr[3] = spec.wdata;
					SP_MR4:  st_nxt.b[b].mr4   = spec.wdata;
					SP_BFO:  st_nxt.b[b].bfo   = spec.wdata;
					default: ;
				endcase
			end
			if (sel_fl[b])
			begin
				st_nxt.b[b].stat[ST_LAST_LSB +: 4] = unit_flags.flags;
				if (unit_flags.unit == U_MUL)
					st_nxt.b[b].stat[ST_MUL_LSB +: 4] =
						st_nxt.b[b].stat[ST_MUL_LSB +: 4]
						| unit_flags.flags;
				if (unit_flags.unit == U_ALU)
					st_nxt.b[b].stat[ST_ADD_LSB +: 4] =
						st_nxt.b[b].stat[ST_ADD_LSB +: 4]
						| unit_flags.flags;
			end

			grp_m = st_nxt.b[b].stat[ST_MUL_LSB +: 4];
			grp_a = st_nxt.b[b].stat[ST_ADD_LSB +: 4];
			st_nxt.exc[b] =
				(st_nxt.b[b].stat[ST_EN_LSB]
				 && (grp_m[F_INV] || grp_a[F_INV]))
				|| (st_nxt.b[b].stat[ST_EN_LSB+1]
				 && (grp_m[F_FIXOVF] || grp_a[F_FIXOVF]
				  || grp_m[F_FLTOVF] || grp_a[F_FLTOVF]))
				|| (st_nxt.b[b].stat[ST_EN_LSB+2]
				 && (grp_m[F_UNF] || grp_a[F_UNF]));
		end

		// Register port: data registers only; the rest reads zero.
		st_nxt.bus_busy  = bus_wr || bus_rd;
		st_nxt.bus_rdata = '0;
		if (bus_rd && (bus_addr <= BUS_MAP_END))
			st_nxt.bus_rdata = st_r.b[bus_addr[5]].regs[bus_addr[4:0]];

		st_nxt.sp_rdata = '0;
		if (spec.rd)
		begin
			case (spec.sel)
				SP_STAT: st_nxt.sp_rdata = st_r.b[sel_sp[1]].stat;
				SP_PR0:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].pr[0];
				SP_PR1:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].pr[1];
				SP_MR0:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].mr[0];
				SP_MR1:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].mr[1];
				SP_MR2:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].mr[2];
				SP_MR3:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].mr[3];
				SP_MR4:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].mr4;
				SP_BFO:  st_nxt.sp_rdata = st_r.b[sel_sp[1]].bfo;
				default: st_nxt.sp_rdata = '0;
			endcase
		end

		// Contents other than the status stay untouched by reset; control and status are cleared.
		if (rst)
		begin
			for (int b = 0; b < 2; b++)
			begin
				st_nxt.b[b].pend = '0;
				st_nxt.b[b].stat = STAT_RST;
			end
			st_nxt.opm       = '0;
			st_nxt.opn       = '0;
			st_nxt.iss_ok    = 1'b0;
			st_nxt.iss_stall = 1'b0;
			st_nxt.iss_err   = 1'b0;
			st_nxt.bus_rdata = '0;
			st_nxt.sp_rdata  = '0;
			st_nxt.bus_busy  = 1'b0;
			st_nxt.exc       = '0;
		end
	end

	always_ff @(posedge mclk)
	begin
		st_r <= st_nxt;
	end

	assign bus_rdata_r    = st_r.bus_rdata;
	assign ext_bus_busy_r = st_r.bus_busy;
	assign issue_ok_r     = st_r.iss_ok;
	assign issue_stall_r  = st_r.iss_stall;
	assign issue_err_r    = st_r.iss_err;
	assign opnd_m_r       = st_r.opm;
	assign opnd_n_r       = st_r.opn;
	assign spec_rdata_r   = st_r.sp_rdata;
	assign bfo_q_r        = {st_r.b[1].bfo, st_r.b[0].bfo};
	assign exc_r          = st_r.exc;

	//------------------------------------------------------------------
	// Checks
	//------------------------------------------------------------------
	logic [31:0] x_peek;
	logic        x_stat_wr;
	assign x_peek    = st_r.b[0].regs[bus_addr[4:0]];
	assign x_stat_wr = spec.wr && (spec.blk != SEL_Y)
	                 && (spec.sel == SP_STAT);

	a_bus_read_x: assert property (@(posedge mclk) disable iff (rst)
		bus_rd && (bus_addr < BUS_Y_BASE)
		|=> bus_rdata_r == $past(x_peek))
		else $error("register port read of block X is wrong");

	a_bus_unmapped: assert property (@(posedge mclk) disable iff (rst)
		bus_rd && (bus_addr > BUS_MAP_END) |=> bus_rdata_r == '0)
		else $error("unmapped address did not read zero");

	a_bus_busy: assert property (@(posedge mclk) disable iff (rst)
		##1 ext_bus_busy_r == $past(bus_rd || bus_wr))
		else $error("external bus busy does not follow access");

	a_dep_stall: assert property (@(posedge mclk) disable iff (rst)
		instr.valid && !bad && conflict
		|=> issue_stall_r && !issue_ok_r)
		else $error("dependent issue was not stalled");

	a_same_reg: assert property (@(posedge mclk) disable iff (rst)
		instr.valid && (instr.srcm == instr.srcn)
		|=> issue_err_r && !issue_ok_r && !issue_stall_r)
		else $error("repeated register in slot not refused");

	a_quad_align: assert property (@(posedge mclk) disable iff (rst)
		instr.valid && (instr.width == W_QUAD)
		&& (instr.srcm[1:0] != 2'b00) |=> issue_err_r)
		else $error("misaligned quad operand accepted");

	a_sticky_keep: assert property (@(posedge mclk) disable iff (rst)
		st_r.b[0].stat[ST_ADD_LSB + F_INV] && !x_stat_wr
		|=> st_r.b[0].stat[ST_ADD_LSB + F_INV])
		else $error("sticky adder flag dropped without a write");

	a_flag_set: assert property (@(posedge mclk) disable iff (rst)
		unit_flags.valid && (unit_flags.blk != SEL_Y)
		&& (unit_flags.unit == U_MUL) && unit_flags.flags[F_UNF]
		|=> st_r.b[0].stat[ST_MUL_LSB + F_UNF]
		&& st_r.b[0].stat[ST_LAST_LSB + F_UNF])
		else $error("multiplier underflow flag not set");

	a_exc_gate: assert property (@(posedge mclk) disable iff (rst)
		!st_r.b[0].stat[ST_EN_LSB] && !st_r.b[0].stat[ST_EN_LSB+1]
		&& !st_r.b[0].stat[ST_EN_LSB+2] |-> !exc_r[0])
		else $error("exception raised with all enables off");

	a_mr_capture: assert property (@(posedge mclk) disable iff (rst)
		wb.valid && wb.to_mr && (wb.blk != SEL_Y) && !spec.wr
		|=> st_r.b[0].mr[0] == $past(wb.data[31:0])
		&& st_r.b[0].mr4 == $past(wb.ovf))
		else $error("multiplier result not captured");

endmodule : dual_compute_register_file

`default_nettype wire

// *** hdl/dcrf_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: Shared constants and types of the dual compute register file.
// Assumes: One core clock; register port uses word indices.
// Notes:   Status layout and bus map are fixed here for both blocks.
//----------------------------------------------------------------------
package dcrf_pkg;

	//------------------------------------------------------------------
	// Sizes and bus map
	//------------------------------------------------------------------
	localparam int          NREG        = 32;
	localparam int          DW          = 32;
	localparam int          QW          = 128;
	localparam int          RIDX_W      = 5;
	localparam int          BUS_AW      = 8;
	localparam logic [7:0]  BUS_X_BASE  = 8'h00;
	localparam logic [7:0]  BUS_Y_BASE  = 8'h20;
	localparam logic [7:0]  BUS_MAP_END = 8'h3f;

	//------------------------------------------------------------------
	// Status register layout
	//------------------------------------------------------------------
	localparam int           ST_MUL_LSB  = 0;
	localparam int           ST_ADD_LSB  = 4;
	localparam int           ST_EN_LSB   = 16;
	localparam int           ST_LAST_LSB = 24;
	localparam int           F_INV       = 0;
	localparam int           F_FIXOVF    = 1;
	localparam int           F_FLTOVF    = 2;
	localparam int           F_UNF       = 3;
	localparam logic [31:0]  STAT_RST    = 32'h0000_0000;
	localparam logic [31:0]  STAT_WMASK  = 32'h0007_00ff;

	//------------------------------------------------------------------
	// Selections
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_XY  = 2'b00,
		SEL_X   = 2'b01,
		SEL_Y   = 2'b10,
		SEL_XY2 = 2'b11
	} blk_sel_e;

	typedef enum logic [1:0] {
		W_SINGLE = 2'b00,
		W_DOUBLE = 2'b01,
		W_QUAD   = 2'b10
	} width_e;

	typedef enum logic [1:0] {
		U_ALU = 2'b00,
		U_MUL = 2'b01,
		U_SHF = 2'b10
	} unit_e;

	typedef enum logic [3:0] {
		SP_STAT = 4'h0,
		SP_PR0  = 4'h1,
		SP_PR1  = 4'h2,
		SP_MR0  = 4'h3,
		SP_MR1  = 4'h4,
		SP_MR2  = 4'h5,
		SP_MR3  = 4'h6,
		SP_MR4  = 4'h7,
		SP_BFO  = 4'h8
	} spec_e;

	//------------------------------------------------------------------
	// Carriers
	//------------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		blk_sel_e    blk;
		width_e      width;
		logic        has_dst;
		logic [4:0]  dst;
		logic [4:0]  srcm;
		logic [4:0]  srcn;
	} instr_s;

	typedef struct packed {
		logic         valid;
		blk_sel_e     blk;
		width_e       width;
		logic [4:0]   dst;
		logic         to_mr;
		logic [127:0] data;
		logic [31:0]  ovf;
	} wb_s;

	typedef struct packed {
		logic         valid;
		blk_sel_e     blk;
		width_e       width;
		logic [4:0]   dst;
		logic         dab;
		logic [1:0]   offs;
		logic [127:0] data;
	} ld_s;

	typedef struct packed {
		logic        valid;
		blk_sel_e    blk;
		unit_e       unit;
		logic [3:0]  flags;
	} flag_s;

	typedef struct packed {
		logic        valid;
		blk_sel_e    blk;
		logic [63:0] data;
	} par_s;

	typedef struct packed {
		logic                 rd;
		logic                 wr;
		blk_sel_e             blk;
		spec_e                sel;
		logic [31:0]          wdata;
	} spec_req_s;

	typedef struct packed {
		logic [31:0][31:0] regs;
		logic [31:0]       pend;
		logic [31:0]       stat;
		logic [1:0][31:0]  pr;
		logic [3:0][31:0]  mr;
		logic [31:0]       mr4;
		logic [31:0]       bfo;
		logic [1:0][127:0] dab;
	} blk_s;

	typedef struct packed {
		blk_s [1:0]         b;
		logic [1:0][127:0]  opm;
		logic [1:0][127:0]  opn;
		logic               iss_ok;
		logic               iss_stall;
		logic               iss_err;
		logic [31:0]        bus_rdata;
		logic [31:0]        sp_rdata;
		logic               bus_busy;
		logic [1:0]         exc;
	} state_s;

endpackage : dcrf_pkg

// *** tb/unit_model.sv ***
// Purpose: Stand-in for the compute units that return results to the file.
// Assumes: Results are singles made from word 0 of the chosen lane.
// Notes:   One result in flight; a later accepted issue with a destination replaces it.
`timescale 1ns/100ps
`default_nettype none

module unit_model
	import dcrf_pkg::*;
#(
	parameter int LAT = 3
)
(
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// Issue side
	input  wire instr_s             instr,
	input  wire logic               issue_ok_r,
	input  wire logic [1:0][QW-1:0] opnd_m_r,
	input  wire logic [1:0][QW-1:0] opnd_n_r,
	input  wire logic               to_mr,
	// Result side
	output var  wb_s                wb
);
	instr_s      last;
	wb_s         res = '0;
	int          cnt = 0;
	logic        l;
	logic [31:0] sum;

	assign l   = (last.blk == SEL_Y);
	assign sum = opnd_m_r[l][31:0] + opnd_n_r[l][31:0];

	initial wb = '0;

	// Idle cycles show the inverted held result with valid low, so stale fields are never reused.
	always @(posedge mclk)
	begin
		last <= instr;
		wb   <= (cnt == 1) ? res : {1'b0, ~res[$bits(wb_s)-2:0]};
		if (rst)
			cnt <= 0;
		else if (issue_ok_r && last.has_dst)
		begin
			cnt <= LAT;
			res <= '{1'b1, last.blk, W_SINGLE, last.dst, to_mr,
				{96'h0, sum}, ~sum};
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
	end

endmodule : unit_model
`default_nettype wire

// *** tb/dual_compute_register_file_test.sv ***
// Purpose: Self-checking bench for the dual compute register file.
// Assumes: The unit model writes results back a fixed time after issue.
// Notes:   Drivers queue expected results; a monitor compares them.
`timescale 1ns/100ps
`default_nettype none

module dual_compute_register_file_test
	import dcrf_pkg::*;
	;
	logic               mclk, rst, bus_wr, bus_rd, bfo_wr, to_mr;
	logic [BUS_AW-1:0]  bus_addr;
	logic [DW-1:0]      bus_wdata, bus_rdata_r, spec_rdata_r, bfo_wdata;
	logic               ext_bus_busy_r, issue_ok_r, issue_stall_r;
	logic               issue_err_r, rd_d, sp_d, any_d;
	logic [1:0][QW-1:0] opnd_m_r, opnd_n_r;
	logic [1:0][DW-1:0] bfo_q_r;
	logic [1:0]         exc_r;
	instr_s             instr;
	wb_s                wb;
	ld_s                ld;
	flag_s              unit_flags;
	par_s               par;
	blk_sel_e           bfo_blk;
	spec_req_s          spec;
	logic [31:0]        mx [64];
	logic [31:0]        q_rd[$], q_sp[$];
	logic [67:0]        q_is[$];
	logic [127:0]       qa, qb;
	logic [255:0]       al;
	blk_sel_e           sels [4] = '{SEL_XY, SEL_X, SEL_Y, SEL_XY2};
	int                 errors, tests_run;

	dual_compute_register_file uut (.mclk, .rst, .bus_addr, .bus_wdata,
		.bus_wr, .bus_rd, .bus_rdata_r, .ext_bus_busy_r, .instr,
		.issue_ok_r, .issue_stall_r, .issue_err_r, .opnd_m_r, .opnd_n_r,
		.wb, .ld, .unit_flags, .par, .bfo_wr, .bfo_blk, .bfo_wdata, .spec,
		.spec_rdata_r, .bfo_q_r, .exc_r);

	unit_model #(.LAT(3)) um (.mclk, .rst, .instr, .issue_ok_r, .opnd_m_r,
		.opnd_n_r, .to_mr, .wb);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	//------------------------------------------------------------------
	// Checking
	//------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize();
		$display("Checks %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	always @(posedge mclk)
	begin
		rd_d  <= bus_rd;
		sp_d  <= spec.rd;
		any_d <= bus_rd | bus_wr;
	end

	always @(negedge mclk)
	begin
		logic [67:0] n;
		if (rd_d)
			check(bus_rdata_r, q_rd.pop_front());
		if (sp_d)
			check(spec_rdata_r, q_sp.pop_front());
		if (any_d)
			check({31'h0, ext_bus_busy_r}, 32'h1);
		if ((issue_ok_r | issue_stall_r | issue_err_r) === 1'b1)
		begin
			n = q_is.pop_front();
			check({issue_ok_r, issue_stall_r, issue_err_r}, n[66:64]);
			if (issue_ok_r)
			begin
				check(opnd_m_r[n[67]][31:0], n[31:0]);
				check(opnd_n_r[n[67]][31:0], n[63:32]);
			end
		end
	end

	//------------------------------------------------------------------
	// Drivers
	//------------------------------------------------------------------
	// A strobe stays up between calls of one kind; nop ends a group.
	task automatic nop();
		bus_wr     <= 1'b0;
		bus_rd     <= 1'b0;
		instr      <= '0;
		spec       <= '0;
		ld         <= '0;
		par        <= '0;
		unit_flags <= '0;
		bfo_wr     <= 1'b0;
		@(posedge mclk);
	endtask : nop

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		bus_wr    <= w;
		bus_rd    <= !w;
		bus_addr  <= a;
		bus_wdata <= d;
		if (!w)
			q_rd.push_back(d);
		@(posedge mclk);
	endtask : bus

	task automatic iss(input blk_sel_e b, input width_e w, input logic h,
		input logic [4:0] d, m, n, input logic [2:0] r,
		input logic [31:0] e);
		instr <= '{1'b1, b, w, h, d, m, n};
		q_is.push_back({b == SEL_Y, r, mx[{b == SEL_Y, n}], e});
		@(posedge mclk);
	endtask : iss

	task automatic sp(input logic w, input blk_sel_e b, input spec_e s,
		input logic [31:0] d);
		spec <= '{!w, w, b, s, d};
		if (!w)
			q_sp.push_back(d);
		@(posedge mclk);
	endtask : sp

	task automatic flg(input unit_e u, input logic [3:0] f);
		unit_flags <= '{1'b1, SEL_X, u, f};
		@(posedge mclk);
	endtask : flg

	task automatic wait_wb();
		int i;
		for (i = 0; i < 50 && wb.valid !== 1'b1; i++)
			@(posedge mclk);
		if (i == 50)
		begin
			errors++;
			summarize();
		end
	endtask : wait_wb

	//------------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------------
	initial
	begin
		errors = 0;
		tests_run = 0;
		rst = 1'b1;
		{bus_wr, bus_rd, bfo_wr, to_mr, bus_addr, bus_wdata} = '0;
		{instr, ld, unit_flags, par, spec, bfo_wdata} = '0;
		bfo_blk = SEL_X;
		void'($urandom(26));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check({30'h0, exc_r}, 32'h0);
		sp(0, SEL_X, SP_STAT, STAT_RST);
		for (int i = 0; i < 64; i++)
		begin
			mx[i] = $urandom;
			bus(1, i[7:0], mx[i]);
		end
		for (int i = 0; i < 64; i++)
			bus(0, i[7:0], mx[i]);
		bus(1, 8'h40, 32'h1234_5678);
		bus(0, 8'h40, 32'h0000_0000);
		nop();
		for (int k = 0; k < 4; k++)
			iss(sels[k], W_SINGLE, 0, 0, 1, 2, 3'b100,
				mx[sels[k] == SEL_Y ? 33 : 1]);
		iss(SEL_X, W_SINGLE, 0, 0, 4, 4, 3'b001, 0);
		iss(SEL_X, W_DOUBLE, 0, 0, 3, 6, 3'b001, 0);
		iss(SEL_X, W_QUAD, 0, 0, 2, 8, 3'b001, 0);
		iss(SEL_X, W_QUAD, 0, 0, 4, 8, 3'b100, mx[4]);
		iss(SEL_Y, W_DOUBLE, 0, 0, 6, 2, 3'b100, mx[38]);
		iss(SEL_X, W_SINGLE, 1, 5, 1, 2, 3'b100, mx[1]);
		iss(SEL_X, W_SINGLE, 0, 0, 5, 2, 3'b010, 0);
		nop();
		wait_wb();
		mx[5] = mx[1] + mx[2];
		iss(SEL_X, W_SINGLE, 0, 0, 5, 2, 3'b100, mx[5]);
		to_mr <= 1'b1;
		iss(SEL_X, W_SINGLE, 1, 9, 1, 2, 3'b100, mx[1]);
		nop();
		wait_wb();
		sp(0, SEL_X, SP_MR0, mx[1] + mx[2]);
		sp(0, SEL_X, SP_MR4, ~(mx[1] + mx[2]));
		nop();
		// A result sent to the multiplier registers must release its target.
		iss(SEL_X, W_SINGLE, 0, 0, 9, 2, 3'b100, mx[9]);
		nop();
		for (int j = 1; j < 9; j++)
		begin
			qa[31:0] = $urandom;
			sp(1, SEL_X, spec_e'(j), qa[31:0]);
			sp(0, SEL_X, spec_e'(j), qa[31:0]);
		end
		nop();
		bus(0, 8'h09, mx[9]);
		bus(0, 8'h05, mx[5]);
		nop();
		sp(1, SEL_X, SP_STAT, 32'hffff_ffff);
		sp(0, SEL_X, SP_STAT, STAT_WMASK);
		sp(1, SEL_X, SP_STAT, 32'h0000_0000);
		nop();
		flg(U_MUL, 4'b0101);
		flg(U_ALU, 4'b0010);
		nop();
		sp(0, SEL_X, SP_STAT, 32'h0200_0025);
		nop();
		flg(U_SHF, 4'b1000);
		nop();
		sp(0, SEL_X, SP_STAT, 32'h0800_0025);
		sp(0, SEL_Y, SP_STAT, 32'h0000_0000);
		sp(1, SEL_X, SP_STAT, 32'h0001_0001);
		nop();
		nop();
		check({30'h0, exc_r}, 32'h1);
		qa = {$urandom, $urandom, $urandom, $urandom};
		qb = {$urandom, $urandom, $urandom, $urandom};
		par <= '{1'b1, SEL_Y, qa[63:0]};
		@(posedge mclk);
		nop();
		sp(0, SEL_Y, SP_PR0, qa[31:0]);
		sp(0, SEL_Y, SP_PR1, qa[63:32]);
		nop();
		bfo_wr    <= 1'b1;
		bfo_blk   <= SEL_Y;
		bfo_wdata <= qb[31:0];
		@(posedge mclk);
		nop();
		check(bfo_q_r[1], qb[31:0]);
		sp(0, SEL_Y, SP_BFO, qb[31:0]);
		nop();
		ld <= '{1'b1, SEL_X, W_QUAD, 5'd8, 1'b1, 2'd0, qa};
		@(posedge mclk);
		ld <= '{1'b1, SEL_X, W_QUAD, 5'd8, 1'b1, 2'd1, qb};
		@(posedge mclk);
		ld <= '{1'b1, SEL_Y, W_SINGLE, 5'd12, 1'b0, 2'd0, qb};
		@(posedge mclk);
		nop();
		al = {qb, qa} >> 32;
		for (int i = 0; i < 4; i++)
			bus(0, 8'h08 + i[7:0], al[i*32 +: 32]);
		bus(0, 8'h2c, qb[31:0]);
		nop();
		rst <= 1'b1;
		nop();
		rst <= 1'b0;
		nop();
		sp(0, SEL_X, SP_STAT, STAT_RST);
		nop();
		nop();
		if (q_rd.size() + q_sp.size() + q_is.size() != 0)
			errors++;
		summarize();
	end

endmodule : dual_compute_register_file_test
`default_nettype wire
